// *** inc/ldm_pkg.sv ***
// constants and types shared by the led driver mode controller
package ldm_pkg;
   localparam int DW = 16;
   localparam int AW = 5;
   localparam int NCH = 12;
   localparam int GW = 7;
   // register indices on the link
   localparam logic [AW-1:0] A_BUS_CFG_A = 5'h00;
   localparam logic [AW-1:0] A_BUS_CFG_B = 5'h01;
   localparam logic [AW-1:0] A_STATUS = 5'h02;
   localparam logic [AW-1:0] A_FAULT_A = 5'h03;
   localparam logic [AW-1:0] A_FAULT_B = 5'h04;
   localparam logic [AW-1:0] A_SA_CFG_A = 5'h05;
   localparam logic [AW-1:0] A_SA_CFG_B = 5'h06;
   localparam logic [AW-1:0] A_SA_SHARED = 5'h07;
   localparam logic [AW-1:0] A_ADDR_SET = 5'h08;
   localparam logic [AW-1:0] A_GAIN0 = 5'h10;
   // bus_output_cfg_a fields
   localparam int F_FLAG = 8;
   localparam int F_DIAG = 9;
   localparam int F_DIM = 10;
   localparam int F_REACT = 11;
   // address_and_standalone_setting fields, then outputs per half register
   localparam int F_PROT = 5;
   localparam int F_REPORT = 6;
   localparam int HALF = 6;
   // values after reset
   localparam logic [DW-1:0] RST_BUS_CFG = 16'h0000;
   localparam logic [DW-1:0] RST_SA_CFG_A = 16'h0FFF;
   localparam logic [DW-1:0] RST_SA_CFG_B = 16'h0FFF;
   localparam logic [DW-1:0] RST_SA_SHARED = 16'h0000;
   localparam logic [DW-1:0] RST_ADDR_SET = 16'h0040;
   localparam logic [GW-1:0] RST_GAIN = 7'h00;

   typedef enum logic [1:0] {
      LDM_OFF = 2'b00,
      LDM_STANDALONE = 2'b01,
      LDM_BUS = 2'b10
   } ldm_mode_t;

   typedef struct packed {
      logic we;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } ldm_req_t;

   typedef struct packed {
      logic digital;
      logic analog;
      logic cfg_sel;
      logic pg;
      logic fault_in;
      logic cs;
      logic twarn;
      logic tshut;
      logic [NCH-1:0] open;
   } ldm_pins_t;
endpackage : ldm_pkg

// *** hw/ldm_mode_ctrl.sv ***
// operating mode controller with register file and link-side access port
// Behaviour
// - standalone uses four non-volatile shadow registers
// - select pin picks one of two standalone configurations
// - errors only checked on enabled outputs
// - standalone detection continuous, fault line if enabled
// - bus mode falls back when digital supply lost
// - address setting gives slave address, zero unprogrammed
// - address setting selects bus protection mode
// - two bus registers: outputs, reaction, diag, dim
// - status register reports diagnosis, thermal, mode
// - two fault registers flag faulty channels
// - twelve writable dimming gain registers
// - both supplies absent means device off
// - digital only: registers reachable, flag kept
// - analog only: standalone, bus off, flag cleared
// - both supplies: flag picks standalone or bus
// - address setting written only with chip select
// - select low gives cfg a, high cfg b
`timescale 1ns/10ps
module ldm_mode_ctrl #(
   parameter int NCH = ldm_pkg::NCH
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire ldm_pkg::ldm_pins_t pins,
   input wire logic lnk_valid,
   input wire ldm_pkg::ldm_req_t lnk_req,
   output logic lnk_ready_q,
   output logic lnk_done_q,
   output logic [ldm_pkg::DW-1:0] lnk_rdata_q,
   output ldm_pkg::ldm_mode_t mode_q,
   output logic i2c_on_q,
   output logic [NCH-1:0] chan_en_q,
   output logic dim_en_q,
   output logic [NCH-1:0][ldm_pkg::GW-1:0] gain_q,
   output logic [4:0] slave_addr_q,
   output logic protect_q,
   output logic fault_line_out_q,
   output logic fault_line_oe_q
);
   // ---------------- link domain ----------------
   logic req_tg_q;
   logic ack_s1_q, ack_s2_q, ack_prev_q;
   ldm_pkg::ldm_req_t hold_q;
   logic ack_tg_q;
   logic [ldm_pkg::DW-1:0] rdata_q;
   wire take = lnk_valid & lnk_ready_q;

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_prev_q <= 1'b0;
      end else begin
         ack_s1_q <= ack_tg_q;
         ack_s2_q <= ack_s1_q;
         ack_prev_q <= ack_s2_q;
      end
   end

   // hold stays stable until the core answers, so it crosses as a word
   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req_tg_q <= 1'b0;
         hold_q <= '0;
         lnk_ready_q <= 1'b0;
         lnk_done_q <= 1'b0;
         lnk_rdata_q <= '0;
      end else begin
         if (take) begin
            req_tg_q <= ~req_tg_q;
            hold_q <= lnk_req;
         end
         lnk_ready_q <= (req_tg_q == ack_s2_q) & ~take;
         lnk_done_q <= ack_s2_q ^ ack_prev_q;
         if (ack_s2_q ^ ack_prev_q) begin
            lnk_rdata_q <= rdata_q;
         end
      end
   end

   // ---------------- core domain ----------------
   ldm_pkg::ldm_pins_t p1_q, s;
   logic req_s1_q, req_s2_q, req_prev_q;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         p1_q <= '0;
         s <= '0;
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_prev_q <= 1'b0;
      end else begin
         p1_q <= pins;
         s <= p1_q;
         req_s1_q <= req_tg_q;
         req_s2_q <= req_s1_q;
         req_prev_q <= req_s2_q;
      end
   end

   logic [ldm_pkg::DW-1:0] bus_a_q, bus_b_q, sa_a_q, sa_b_q, sa_sh_q, aset_q;
   logic [NCH-1:0] fault_q;
   logic [NCH-1:0] act;
   ldm_pkg::ldm_mode_t mode_d;

   wire go = req_s2_q ^ req_prev_q;
   // host register writes only taken while the digital supply is there; reads are answered regardless
   wire wr = go & hold_q.we & s.digital;
   wire nv_wr = wr & s.cs;
   wire [ldm_pkg::DW-1:0] wd = hold_q.wdata;
   wire [ldm_pkg::AW-1:0] wa = hold_q.addr;
   wire flag = bus_a_q[ldm_pkg::F_FLAG];
   // a cleared address is only legal before the part is programmed
   wire addr_ok = (wd[4:0] != 5'h00) | (aset_q[4:0] == 5'h00);
   wire flag_kill = s.analog & ~s.digital;

   // mode table
   assign mode_d = (!s.analog && !s.digital) ? ldm_pkg::LDM_OFF :
                   (s.digital && flag) ? ldm_pkg::LDM_BUS :
                   ldm_pkg::LDM_STANDALONE;

   wire [NCH-1:0] sa_out = s.cfg_sel ? sa_b_q[NCH-1:0] : sa_a_q[NCH-1:0];
   wire [NCH-1:0] bus_out = {bus_b_q[ldm_pkg::HALF-1:0], bus_a_q[ldm_pkg::HALF-1:0]};
   assign act = (mode_q == ldm_pkg::LDM_BUS) ? bus_out :
                (mode_q == ldm_pkg::LDM_STANDALONE) ? sa_out : '0;
   wire diag_on = (mode_q == ldm_pkg::LDM_STANDALONE) | bus_a_q[ldm_pkg::F_DIAG];
   wire [NCH-1:0] detect = s.open & act & {NCH{s.pg & diag_on}};
   wire any_err = (|detect) | s.tshut;
   wire report = (mode_q == ldm_pkg::LDM_STANDALONE) ? aset_q[ldm_pkg::F_REPORT] :
                 (mode_q == ldm_pkg::LDM_BUS);
   wire ext_stop = (mode_q == ldm_pkg::LDM_BUS) & bus_a_q[ldm_pkg::F_REACT] & s.fault_in & s.pg;
   wire [NCH-1:0] fclr = {wr && wa == ldm_pkg::A_FAULT_B ? wd[ldm_pkg::HALF-1:0] : 6'h00,
                          wr && wa == ldm_pkg::A_FAULT_A ? wd[ldm_pkg::HALF-1:0] : 6'h00};
   wire [ldm_pkg::DW-1:0] status = {10'h000, s.fault_in, s.analog, mode_q == ldm_pkg::LDM_BUS,
                                    s.tshut, s.twarn, |fault_q};

   function automatic logic [ldm_pkg::DW-1:0] rd_mux(input logic [ldm_pkg::AW-1:0] a);
      logic [ldm_pkg::DW-1:0] r;
      r = '0;
      case (a)
         ldm_pkg::A_BUS_CFG_A: r = bus_a_q;
         ldm_pkg::A_BUS_CFG_B: r = bus_b_q;
         ldm_pkg::A_STATUS: r = status;
         ldm_pkg::A_FAULT_A: r = {10'h000, fault_q[ldm_pkg::HALF-1:0]};
         ldm_pkg::A_FAULT_B: r = {10'h000, fault_q[NCH-1:ldm_pkg::HALF]};
         ldm_pkg::A_SA_CFG_A: r = sa_a_q;
         ldm_pkg::A_SA_CFG_B: r = sa_b_q;
         ldm_pkg::A_SA_SHARED: r = sa_sh_q;
         ldm_pkg::A_ADDR_SET: r = aset_q;
         default: begin
            if (a >= ldm_pkg::A_GAIN0 && a < ldm_pkg::A_GAIN0 + 5'(NCH)) begin
               r = {9'h000, gain_q[4'(a - ldm_pkg::A_GAIN0)]};
            end
         end
      endcase
      return r;
   endfunction : rd_mux

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_tg_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_tg_q <= ack_tg_q ^ go;
         if (go) begin
            rdata_q <= rd_mux(wa);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_a_q <= ldm_pkg::RST_BUS_CFG;
         bus_b_q <= ldm_pkg::RST_BUS_CFG;
      end else begin
         if (flag_kill) begin
            bus_a_q[ldm_pkg::F_FLAG] <= 1'b0;
         end else if (wr && wa == ldm_pkg::A_BUS_CFG_A) begin
            bus_a_q <= wd;
         end
         if (wr && wa == ldm_pkg::A_BUS_CFG_B) begin
            bus_b_q <= wd;
         end
      end
   end

   // shadows of the one-time memory; reset values stand for its content
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sa_a_q <= ldm_pkg::RST_SA_CFG_A;
         sa_b_q <= ldm_pkg::RST_SA_CFG_B;
         sa_sh_q <= ldm_pkg::RST_SA_SHARED;
         aset_q <= ldm_pkg::RST_ADDR_SET;
      end else begin
         if (nv_wr && wa == ldm_pkg::A_SA_CFG_A) sa_a_q <= wd;
         if (nv_wr && wa == ldm_pkg::A_SA_CFG_B) sa_b_q <= wd;
         if (nv_wr && wa == ldm_pkg::A_SA_SHARED) sa_sh_q <= wd;
         if (nv_wr && wa == ldm_pkg::A_ADDR_SET && addr_ok) aset_q <= wd;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_gain
         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               gain_q[g] <= ldm_pkg::RST_GAIN;
            end else if (wr && wa == ldm_pkg::A_GAIN0 + 5'(g)) begin
               gain_q[g] <= wd[ldm_pkg::GW-1:0];
            end
         end
      end
   endgenerate

   // set beats clear so a fault in the clearing cycle stays flagged
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_q <= '0;
         mode_q <= ldm_pkg::LDM_OFF;
         i2c_on_q <= 1'b0;
         chan_en_q <= '0;
         dim_en_q <= 1'b0;
         slave_addr_q <= 5'h00;
         protect_q <= 1'b0;
         fault_line_out_q <= 1'b0;
         fault_line_oe_q <= 1'b0;
      end else begin
         fault_q <= (fault_q & ~fclr) | detect;
         mode_q <= mode_d;
         i2c_on_q <= s.digital;
         chan_en_q <= (s.tshut || ext_stop) ? '0 : act;
         dim_en_q <= (mode_q == ldm_pkg::LDM_BUS) & bus_a_q[ldm_pkg::F_DIM];
         slave_addr_q <= aset_q[4:0];
         protect_q <= aset_q[ldm_pkg::F_PROT];
         fault_line_out_q <= report & any_err;
         fault_line_oe_q <= report & any_err;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence sa_b_sel;
      mode_q == ldm_pkg::LDM_STANDALONE && s.cfg_sel && !s.tshut;
   endsequence
   a_off_dark: assert property (mode_q == ldm_pkg::LDM_OFF |=> chan_en_q == '0)
      else $error("outputs on while device off");
   a_flag_clear: assert property (flag_kill |=> !flag ##1 mode_q == ldm_pkg::LDM_STANDALONE)
      else $error("bus flag not cleared without digital supply");
   a_fall_back: assert property (s.analog && !s.digital |=> mode_q == ldm_pkg::LDM_STANDALONE)
      else $error("no fallback to standalone");
   a_sel_b: assert property (sa_b_sel |=> chan_en_q == $past(sa_b_q[NCH-1:0]))
      else $error("select high did not give cfg b");
   a_bus_outs: assert property (mode_q == ldm_pkg::LDM_BUS && !s.tshut && !ext_stop
      |=> chan_en_q == $past(bus_out))
      else $error("bus configuration not applied");
   a_nv_guard: assert property (go && hold_q.we && !s.cs |=> $stable(aset_q) && $stable(sa_a_q))
      else $error("shadow register written without chip select");
   a_fault_set: assert property (detect != '0 |=> (fault_q & $past(detect)) == $past(detect))
      else $error("detected fault not flagged");
   a_off_chan: assert property (##1 (fault_q & ~$past(fault_q) & ~$past(act)) == '0)
      else $error("fault flagged on disabled output");
   a_mode_follow: assert property (##1 mode_q == $past(mode_d))
      else $error("mode not following inputs");
   a_prot_bit: assert property (##1 protect_q == $past(aset_q[ldm_pkg::F_PROT]))
      else $error("protection mode not taken from setting");
endmodule : ldm_mode_ctrl

// *** tb/ldm_link_host.sv ***
// link host model issuing one register access at a time
`timescale 1ns/10ps
module ldm_link_host (
   input wire logic link_clk,
   input wire logic lnk_ready_q,
   input wire logic lnk_done_q,
   input wire logic [ldm_pkg::DW-1:0] lnk_rdata_q,
   output logic lnk_valid,
   output ldm_pkg::ldm_req_t lnk_req
);
   initial begin
      lnk_valid = 1'b0;
      lnk_req = '0;
   end
   // request held from launch to the taking edge; released fields are inverted so stale data is never trusted
   task xfer(input logic we, input logic [ldm_pkg::AW-1:0] a, input logic [ldm_pkg::DW-1:0] d,
      output logic [ldm_pkg::DW-1:0] r);
      int n;
      begin
         n = 0;
         r = 'x;
         @(posedge link_clk);
         lnk_valid <= 1'b1;
         lnk_req <= '{we: we, addr: a, wdata: d};
         @(negedge link_clk);
         while (lnk_ready_q !== 1'b1 && n < 50) begin
            @(negedge link_clk);
            n++;
         end
         @(posedge link_clk);
         lnk_valid <= 1'b0;
         lnk_req <= ldm_pkg::ldm_req_t'(~lnk_req);
         while (lnk_done_q !== 1'b1 && n < 200) begin
            @(negedge link_clk);
            n++;
         end
         if (lnk_done_q === 1'b1) r = lnk_rdata_q;
         @(posedge link_clk);
      end
   endtask : xfer
endmodule : ldm_link_host

// *** tb/ldm_mode_ctrl_bench.sv ***
// self-checking bench for the mode controller
`timescale 1ns/10ps
module ldm_mode_ctrl_bench;
   typedef struct packed {
      logic dig;
      logic ana;
      logic wr;
      logic flag;
      logic chk;
      ldm_pkg::ldm_mode_t mode;
      logic [11:0] chan;
   } ldm_row_t;
   logic ref_clk, link_clk, sys_rst, lnk_valid, lnk_ready_q, lnk_done_q, i2c_on_q, dim_en_q, protect_q;
   logic fl_out, fl_oe;
   ldm_pkg::ldm_pins_t pins, p;
   ldm_pkg::ldm_req_t lnk_req;
   logic [15:0] lnk_rdata_q, rd;
   ldm_pkg::ldm_mode_t mode_q;
   logic [11:0] chan_en_q;
   logic [11:0][6:0] gain_q;
   logic [4:0] slave_addr_q;
   int bad_count, checks;
   ldm_row_t rows [6];

   ldm_mode_ctrl ldm_mode_ctrl_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk), .pins(pins),
      .lnk_valid(lnk_valid), .lnk_req(lnk_req), .lnk_ready_q(lnk_ready_q), .lnk_done_q(lnk_done_q),
      .lnk_rdata_q(lnk_rdata_q), .mode_q(mode_q), .i2c_on_q(i2c_on_q), .chan_en_q(chan_en_q),
      .dim_en_q(dim_en_q), .gain_q(gain_q), .slave_addr_q(slave_addr_q), .protect_q(protect_q),
      .fault_line_out_q(fl_out), .fault_line_oe_q(fl_oe));
   ldm_link_host ldm_link_host_i (.link_clk(link_clk), .lnk_ready_q(lnk_ready_q), .lnk_done_q(lnk_done_q),
      .lnk_rdata_q(lnk_rdata_q), .lnk_valid(lnk_valid), .lnk_req(lnk_req));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // link clock offset by 7 ns; every fifth link edge still lines up with a core clock rising edge
   initial begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask : chk

   task setp(input ldm_pkg::ldm_pins_t v);
      @(posedge ref_clk);
      pins <= v;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : setp

   task wr(input logic [4:0] a, input logic [15:0] d);
      ldm_link_host_i.xfer(1'b1, a, d, rd);
      chk("wr_answer", 16'h0000, 16'($isunknown(rd)));
      repeat (4) @(negedge ref_clk);
   endtask : wr

   task rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
      ldm_link_host_i.xfer(1'b0, a, 16'h0000, rd);
      chk(nm, e, rd);
   endtask : rdc

   task give_verdict;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end

   initial begin
      sys_rst = 1'b1;
      pins = '0;
      p = '0;
      bad_count = 0;
      checks = 0;
      rows[0] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, ldm_pkg::LDM_STANDALONE, 12'h000};
      rows[1] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, ldm_pkg::LDM_BUS, 12'h000};
      rows[2] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, ldm_pkg::LDM_BUS, 12'hA95};
      rows[3] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, ldm_pkg::LDM_STANDALONE, 12'hFFF};
      rows[4] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, ldm_pkg::LDM_STANDALONE, 12'hFFF};
      rows[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ldm_pkg::LDM_OFF, 12'h000};
      // reset is asynchronous; ten core cycles still hold one rising link edge
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      setp(p);
      chk("mode", 16'(ldm_pkg::LDM_OFF), 16'(mode_q));
      p.digital = 1'b1;
      setp(p);
      wr(ldm_pkg::A_BUS_CFG_B, 16'h002A);
      foreach (rows[i]) begin
         p.digital = rows[i].dig;
         p.analog = rows[i].ana;
         setp(p);
         if (rows[i].wr) wr(ldm_pkg::A_BUS_CFG_A, {7'h00, rows[i].flag, 8'h15});
         chk("mode", 16'(rows[i].mode), 16'(mode_q));
         chk("i2c", 16'(rows[i].dig), 16'(i2c_on_q));
         if (rows[i].chk) chk("chan", 16'(rows[i].chan), 16'(chan_en_q));
      end
      p.digital = 1'b1;
      p.analog = 1'b1;
      p.cs = 1'b1;
      p.pg = 1'b1;
      setp(p);
      wr(ldm_pkg::A_SA_CFG_A, 16'h00A5);
      chk("chan", 16'h00A5, 16'(chan_en_q));
      p.cfg_sel = 1'b1;
      setp(p);
      chk("chan", 16'h0FFF, 16'(chan_en_q));
      p.cfg_sel = 1'b0;
      p.open = 12'hFFF;
      setp(p);
      rdc("fault_a", ldm_pkg::A_FAULT_A, 16'h0025);
      rdc("fault_b", ldm_pkg::A_FAULT_B, 16'h0002);
      chk("fl_oe", 16'h0001, 16'(fl_oe));
      wr(ldm_pkg::A_ADDR_SET, 16'h0023);
      chk("addr", 16'h0003, 16'(slave_addr_q));
      chk("prot", 16'h0001, 16'(protect_q));
      chk("fl_oe", 16'h0000, 16'(fl_oe));
      wr(ldm_pkg::A_ADDR_SET, 16'h0000);
      chk("addr", 16'h0003, 16'(slave_addr_q));
      p.tshut = 1'b1;
      setp(p);
      rdc("status", ldm_pkg::A_STATUS, 16'h0015);
      chk("chan", 16'h0000, 16'(chan_en_q));
      p.tshut = 1'b0;
      p.cs = 1'b0;
      setp(p);
      wr(ldm_pkg::A_SA_CFG_A, 16'h0FFF);
      rdc("sa_cfg_a", ldm_pkg::A_SA_CFG_A, 16'h00A5);
      wr(ldm_pkg::A_BUS_CFG_A, 16'h0515);
      rdc("bus_cfg_a", ldm_pkg::A_BUS_CFG_A, 16'h0515);
      chk("dim", 16'h0001, 16'(dim_en_q));
      for (int i = 0; i < 12; i++) begin
         wr(ldm_pkg::A_GAIN0 + 5'(i), 16'(i + 3));
         chk("gain", 16'(i + 3), 16'(gain_q[i]));
      end
      // diagnosis off in bus mode, so a clear sticks
      wr(ldm_pkg::A_FAULT_A, 16'h0025);
      rdc("fault_a", ldm_pkg::A_FAULT_A, 16'h0000);
      wr(ldm_pkg::A_BUS_CFG_A, 16'h0F15);
      rdc("fault_b", ldm_pkg::A_FAULT_B, 16'h002A);
      chk("fl_out", 16'h0001, 16'(fl_out));
      chk("fl_oe", 16'h0001, 16'(fl_oe));
      // a clear in the cycle of a new detection leaves the bit set
      wr(ldm_pkg::A_FAULT_A, 16'h003F);
      rdc("fault_a", ldm_pkg::A_FAULT_A, 16'h0015);
      p.fault_in = 1'b1;
      p.twarn = 1'b1;
      setp(p);
      chk("chan", 16'h0000, 16'(chan_en_q));
      rdc("status", ldm_pkg::A_STATUS, 16'h003B);
      // second reset in mid-run: volatile state back to reset values
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      setp(p);
      chk("mode", 16'(ldm_pkg::LDM_STANDALONE), 16'(mode_q));
      chk("gain", 16'(ldm_pkg::RST_GAIN), 16'(gain_q[0]));
      chk("addr", 16'(ldm_pkg::RST_ADDR_SET[4:0]), 16'(slave_addr_q));
      rdc("bus_cfg_a", ldm_pkg::A_BUS_CFG_A, ldm_pkg::RST_BUS_CFG);
      give_verdict();
   end
endmodule : ldm_mode_ctrl_bench
